// *** xio_pkg.sv ***
/*
 Constants for the extended I/O block port: point numbering, command codes,
 reset values. Assumes a single 20 MHz clock domain.
*/
package xio_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] GEN_OUT_RESET = 8'h00;
   localparam logic [63:0] EXT_OUT_RESET = 64'h0;
   localparam logic [7:0] GEN_IN_IDLE = 8'hFF;
   localparam logic [63:0] EXT_IN_IDLE = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] EXT_OE_N_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [6:0] GEN_FIRST = 7'h01;
   localparam logic [6:0] GEN_LAST = 7'h08;
   localparam logic [6:0] EXT_FIRST = 7'h11;
   localparam logic [6:0] EXT_LAST = 7'h50;
   localparam logic [3:0] BLK_GEN = 4'h0;
   localparam logic [3:0] BLK_FIRST = 4'h2;
   localparam logic [3:0] BLK_LAST = 4'h9;
   localparam logic [4:0] GROUP_PRESENT_ALL = 5'h1F;

   typedef enum logic [2:0]
   {
      XIO_CMD_DIR = 3'b000,
      XIO_CMD_SAVE = 3'b001,
      XIO_CMD_SET = 3'b010,
      XIO_CMD_CLEAR = 3'b011,
      XIO_CMD_COND = 3'b100,
      XIO_CMD_GROUP = 3'b101,
      XIO_CMD_BLKRD = 3'b110,
      XIO_CMD_PTRD = 3'b111
   } xio_cmd_t;
endpackage : xio_pkg

// *** xio_port.sv ***
/*
 Extended I/O block port: 8 general outputs, 8 general inputs, 64 extended
 points in eight blocks. Commands arrive as one-cycle strobes from the
 command interpreter on the same clock. Pins pass two flip-flops.
 Nonvolatile storage lives outside: save pulse plus data, startup values in.
*/
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - 64 extended points, direction per eight-point group
// - Blocks 2 to 9, indices 17 to 80
// - Direction mask bit one means output
// - Mask bit 0 is block 2, bit 7 block 9
// - No saved setting: mask zero, all inputs
// - Save writes mask and outputs to nonvolatile store
// - Set and clear drive one point, 1-8, 17-80
// - Conditional write sets point from supplied value
// - Group write: 8-bit then four 16-bit values
// - 16-bit groups map 17-32 to 65-80, LSB first
// - Group bits on input points are discarded
// - Supplied group overwrites; omitted group keeps state
// - Block read accepts 0, 2-9, returns eight bits
// - Point query 1-8, 17-80; 17 is block 2 LSB
// - Open input reads one through pull-up
//////////////////////////////////////////////////////////////////////////////
module xio_port
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_i,
   input wire logic [6:0] cmd_index_i,
   input wire logic cmd_value_i,
   input wire logic [7:0] cmd_dir_i,
   input wire logic [7:0] group_gen_i,
   input wire logic [63:0] group_ext_i,
   input wire logic [4:0] group_present_i,
   input wire logic saved_valid_i,
   input wire logic [7:0] saved_dir_i,
   input wire logic [7:0] saved_gen_i,
   input wire logic [63:0] saved_ext_i,
   input wire logic [7:0] gen_in_i,
   input wire logic [63:0] ext_in_i,
   output logic [7:0] gen_out_o,
   output logic [63:0] ext_out_o,
   output logic [63:0] ext_oe_n_o,
   output logic [7:0] dir_o,
   output logic save_o,
   output logic [7:0] save_dir_o,
   output logic [7:0] save_gen_o,
   output logic [63:0] save_ext_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic cmd_error_o
);

   typedef struct packed
   {
      logic loaded;
      logic [7:0] gen_in_s1;
      logic [7:0] gen_in_s2;
      logic [63:0] ext_in_s1;
      logic [63:0] ext_in_s2;
      logic [7:0] dir;
      logic [7:0] gen_out;
      logic [63:0] ext_out;
      logic [63:0] ext_oe_n;
      logic save;
      logic [7:0] save_dir;
      logic [7:0] save_gen;
      logic [63:0] save_ext;
      logic rd_valid;
      logic [7:0] rd_data;
      logic cmd_error;
   } xio_state_t;

   // Pins idle high through the pull-ups; all drivers start released
   localparam xio_state_t ST_RESET = '{
      gen_in_s1: xio_pkg::GEN_IN_IDLE, gen_in_s2: xio_pkg::GEN_IN_IDLE,
      ext_in_s1: xio_pkg::EXT_IN_IDLE, ext_in_s2: xio_pkg::EXT_IN_IDLE,
      dir: xio_pkg::DIR_RESET, gen_out: xio_pkg::GEN_OUT_RESET,
      ext_out: xio_pkg::EXT_OUT_RESET, ext_oe_n: xio_pkg::EXT_OE_N_RESET,
      default: '0};

   xio_state_t st;
   xio_state_t next_st;
   logic [1:0] rst_sync;
   logic rst_n;

   assign rst_n = rst_sync[1];

   ///////////////////////////////////////////////////////////////////////////
   // Index decoding, shared by writes and reads
   function automatic logic idx_is_gen(input logic [6:0] idx);
      idx_is_gen = (idx >= xio_pkg::GEN_FIRST) && (idx <= xio_pkg::GEN_LAST);
   endfunction : idx_is_gen

   function automatic logic idx_is_ext(input logic [6:0] idx);
      idx_is_ext = (idx >= xio_pkg::EXT_FIRST) && (idx <= xio_pkg::EXT_LAST);
   endfunction : idx_is_ext

   // Index 17 maps to extended bit 0
   function automatic logic [5:0] ext_bit(input logic [6:0] idx);
      ext_bit = 6'(idx - xio_pkg::EXT_FIRST);
   endfunction : ext_bit

   function automatic logic [2:0] gen_bit(input logic [6:0] idx);
      gen_bit = 3'(idx - xio_pkg::GEN_FIRST);
   endfunction : gen_bit

   // Per-point output enable from the block mask
   function automatic logic [63:0] dir_expand(input logic [7:0] dir);
      for (int b = 0; b < 8; b++)
         dir_expand[b*8 +: 8] = {8{dir[b]}};
   endfunction : dir_expand

   ///////////////////////////////////////////////////////////////////////////
   // Reset release
   // Own register: it runs on the raw reset, the state on its copy
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   always_comb
   begin
      logic [63:0] ext_rd;
      logic [63:0] oe;
      logic [63:0] gmask;
      logic [3:0] blk;
      logic [3:0] boff;
      logic v;
      next_st = st;
      next_st.gen_in_s1 = gen_in_i;
      next_st.gen_in_s2 = st.gen_in_s1;
      next_st.ext_in_s1 = ext_in_i;
      next_st.ext_in_s2 = st.ext_in_s1;
      next_st.save = 1'b0;
      next_st.rd_valid = 1'b0;
      next_st.cmd_error = 1'b0;
      oe = dir_expand(st.dir);
      // Output points read back the driven level; pull-up makes open read 1
      ext_rd = (st.ext_out & oe) | (st.ext_in_s2 & ~oe);
      gmask = 64'h0;
      blk = cmd_index_i[3:0];
      boff = blk - xio_pkg::BLK_FIRST;
      v = (cmd_i == xio_pkg::XIO_CMD_SET) ||
          ((cmd_i == xio_pkg::XIO_CMD_COND) && cmd_value_i);

      if (!st.loaded)
      begin
         // Startup from store, or all inputs with outputs low
         next_st.loaded = 1'b1;
         if (saved_valid_i)
         begin
            next_st.dir = saved_dir_i;
            next_st.gen_out = saved_gen_i;
            next_st.ext_out = saved_ext_i;
         end
         else
            next_st.dir = xio_pkg::DIR_RESET;
      end
      else if (cmd_valid_i)
      begin
         unique case (xio_pkg::xio_cmd_t'(cmd_i))
            xio_pkg::XIO_CMD_DIR:
               next_st.dir = cmd_dir_i;
            xio_pkg::XIO_CMD_SAVE:
            begin
               next_st.save = 1'b1;
               next_st.save_dir = st.dir;
               next_st.save_gen = st.gen_out;
               next_st.save_ext = st.ext_out;
            end
            xio_pkg::XIO_CMD_SET, xio_pkg::XIO_CMD_CLEAR,
            xio_pkg::XIO_CMD_COND:
            begin
               // Input points keep their latch untouched
               if (idx_is_gen(cmd_index_i))
                  next_st.gen_out[gen_bit(cmd_index_i)] = v;
               else if (idx_is_ext(cmd_index_i) && oe[ext_bit(cmd_index_i)])
                  next_st.ext_out[ext_bit(cmd_index_i)] = v;
               else if (!idx_is_ext(cmd_index_i))
                  next_st.cmd_error = 1'b1;
            end
            xio_pkg::XIO_CMD_GROUP:
            begin
               if (group_present_i[0])
                  next_st.gen_out = group_gen_i;
               for (int g = 0; g < 4; g++)
                  gmask[g*16 +: 16] = {16{group_present_i[g+1]}};
               gmask = gmask & oe;
               next_st.ext_out = (group_ext_i & gmask) |
                                 (st.ext_out & ~gmask);
            end
            xio_pkg::XIO_CMD_BLKRD:
            begin
               if (blk == xio_pkg::BLK_GEN && cmd_index_i[6:4] == 3'h0)
               begin
                  next_st.rd_valid = 1'b1;
                  next_st.rd_data = st.gen_in_s2;
               end
               else if (cmd_index_i[6:4] == 3'h0 &&
                        blk >= xio_pkg::BLK_FIRST &&
                        blk <= xio_pkg::BLK_LAST)
               begin
                  next_st.rd_valid = 1'b1;
                  next_st.rd_data = ext_rd[boff[2:0]*8 +: 8];
               end
               else
                  next_st.cmd_error = 1'b1;
            end
            xio_pkg::XIO_CMD_PTRD:
            begin
               if (idx_is_gen(cmd_index_i))
               begin
                  next_st.rd_valid = 1'b1;
                  next_st.rd_data = 8'(st.gen_in_s2[gen_bit(cmd_index_i)]);
               end
               else if (idx_is_ext(cmd_index_i))
               begin
                  next_st.rd_valid = 1'b1;
                  next_st.rd_data = 8'(ext_rd[ext_bit(cmd_index_i)]);
               end
               else
                  next_st.cmd_error = 1'b1;
            end
         endcase
      end
      // Drivers follow the new mask the cycle it is stored
      next_st.ext_oe_n = ~dir_expand(next_st.dir);
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         st <= ST_RESET;
      else
         st <= next_st;
   end

   assign gen_out_o = st.gen_out;
   assign ext_out_o = st.ext_out;
   assign ext_oe_n_o = st.ext_oe_n;
   assign dir_o = st.dir;
   assign save_o = st.save;
   assign save_dir_o = st.save_dir;
   assign save_gen_o = st.save_gen;
   assign save_ext_o = st.save_ext;
   assign rd_valid_o = st.rd_valid;
   assign rd_data_o = st.rd_data;
   assign cmd_error_o = st.cmd_error;

   ///////////////////////////////////////////////////////////////////////////
   // Checks
   property p_oe_follows_dir;
      @(posedge clk_i) disable iff (!rst_n)
      st.ext_oe_n == ~dir_expand(st.dir);
   endproperty
   a_oe_follows_dir: assert property (p_oe_follows_dir)
      else $error("output enables disagree with direction mask");

   property p_dir_load;
      @(posedge clk_i) disable iff (!rst_n)
      st.loaded && cmd_valid_i && cmd_i == 3'b000 |=>
         st.dir == $past(cmd_dir_i);
   endproperty
   a_dir_load: assert property (p_dir_load)
      else $error("direction mask not loaded");

   property p_default_dir;
      @(posedge clk_i) disable iff (!rst_n)
      !st.loaded && !saved_valid_i |=> st.dir == 8'h00;
   endproperty
   a_default_dir: assert property (p_default_dir)
      else $error("startup direction not zero");

   property p_save;
      @(posedge clk_i) disable iff (!rst_n)
      st.loaded && cmd_valid_i && cmd_i == 3'b001 |=>
         save_o && save_dir_o == $past(st.dir) &&
         save_ext_o == $past(st.ext_out) && save_gen_o == $past(st.gen_out);
   endproperty
   a_save: assert property (p_save)
      else $error("save output wrong");

   property p_input_untouched;
      @(posedge clk_i) disable iff (!rst_n)
      st.loaded && cmd_valid_i && cmd_i == 3'b101 |=>
         ((st.ext_out ^ $past(st.ext_out)) & $past(st.ext_oe_n)) == 64'h0;
   endproperty
   a_input_untouched: assert property (p_input_untouched)
      else $error("group write changed an input point");

   property p_set_point;
      @(posedge clk_i) disable iff (!rst_n)
      st.loaded && cmd_valid_i && cmd_i == 3'b010 && cmd_index_i == 7'h11 &&
         st.dir[0] |=> st.ext_out[0];
   endproperty
   a_set_point: assert property (p_set_point)
      else $error("set of point 17 failed");

   property p_one_pulse;
      @(posedge clk_i) disable iff (!rst_n)
      save_o |=> !save_o || $past(cmd_valid_i && cmd_i == 3'b001);
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("save pulse stuck");

   property p_read_answer;
      @(posedge clk_i) disable iff (!rst_n)
      st.loaded && cmd_valid_i && cmd_i == 3'b110 |=> rd_valid_o ^ cmd_error_o;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("block read gave no single answer");

   c_group: cover property (@(posedge clk_i) disable iff (!rst_n)
      cmd_valid_i && cmd_i == 3'b101 && group_present_i == 5'h11);
   c_save: cover property (@(posedge clk_i) disable iff (!rst_n) save_o);
   c_read: cover property (@(posedge clk_i) disable iff (!rst_n) rd_valid_o);
endmodule : xio_port

// *** xio_rack_model.sv ***
/*
 Model of the external rack on the extended points: pull-ups on every
 released point, switches that ground them, driven points read back.
 Assumes switch states come from the bench.
*/
module xio_rack_model
(
   input wire logic [63:0] ext_out_i,
   input wire logic [63:0] ext_oe_n_i,
   input wire logic [63:0] closed_i,
   output logic [63:0] ext_in_o
);
   timeunit 1ns;
   timeprecision 1ns;
   //////////////////////////////////////////////////////////////////////////
   // Released point goes to the pull-up, never keeps the old level
   always_comb
   begin
      for (int i = 0; i < 64; i++)
      begin
         ext_in_o[i] = ext_oe_n_i[i] ? ~closed_i[i] : ext_out_i[i];
      end
   end
endmodule : xio_rack_model

// *** xio_port_tb.sv ***
/*
 Self-checking bench for the extended I/O block port.
 Assumes the rack model beside it and a 20 MHz clock.
*/
module xio_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [2:0] C_DIR = xio_pkg::XIO_CMD_DIR;
   localparam logic [2:0] C_SAVE = xio_pkg::XIO_CMD_SAVE;
   localparam logic [2:0] C_SET = xio_pkg::XIO_CMD_SET;
   localparam logic [2:0] C_CLR = xio_pkg::XIO_CMD_CLEAR;
   localparam logic [2:0] C_COND = xio_pkg::XIO_CMD_COND;
   localparam logic [2:0] C_GRP = xio_pkg::XIO_CMD_GROUP;
   localparam logic [2:0] C_BRD = xio_pkg::XIO_CMD_BLKRD;
   localparam logic [2:0] C_PRD = xio_pkg::XIO_CMD_PTRD;
   logic clk_i = 1'b0, resetn_i = 1'b1, cmd_valid_i = 1'b0, cmd_value_i = 1'b0;
   logic [2:0] cmd_i = 3'h0;
   logic [6:0] cmd_index_i = 7'h00;
   logic [7:0] cmd_dir_i = 8'h00, group_gen_i = 8'h00, gen_in_i = 8'h00;
   logic [63:0] group_ext_i = 64'h0, saved_ext_i = 64'h0, closed = 64'h0;
   logic [4:0] group_present_i = 5'h00;
   logic saved_valid_i = 1'b0;
   logic [7:0] saved_dir_i = 8'h00, saved_gen_i = 8'h00;
   logic [63:0] ext_in_i, ext_out_o, ext_oe_n_o, save_ext_o;
   logic [7:0] gen_out_o, dir_o, save_dir_o, save_gen_o, rd_data_o;
   logic save_o, rd_valid_o, cmd_error_o;
   logic [7:0] st_dir, st_gen, exp_dir, exp_gen;
   logic [63:0] st_ext, exp_ext;
   logic [4:0] st_pres;
   int err_total = 0, compares = 0, cyc = 0;
   //////////////////////////////////////////////////////////////////////////
   xio_port xio_port_inst (.clk_i(clk_i), .resetn_i(resetn_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_index_i(cmd_index_i),
      .cmd_value_i(cmd_value_i), .cmd_dir_i(cmd_dir_i),
      .group_gen_i(group_gen_i), .group_ext_i(group_ext_i),
      .group_present_i(group_present_i), .saved_valid_i(saved_valid_i),
      .saved_dir_i(saved_dir_i), .saved_gen_i(saved_gen_i),
      .saved_ext_i(saved_ext_i), .gen_in_i(gen_in_i), .ext_in_i(ext_in_i),
      .gen_out_o(gen_out_o), .ext_out_o(ext_out_o), .ext_oe_n_o(ext_oe_n_o),
      .dir_o(dir_o), .save_o(save_o), .save_dir_o(save_dir_o),
      .save_gen_o(save_gen_o), .save_ext_o(save_ext_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .cmd_error_o(cmd_error_o));
   xio_rack_model xio_rack_model_inst (.ext_out_i(ext_out_o),
      .ext_oe_n_i(ext_oe_n_o), .closed_i(closed), .ext_in_o(ext_in_i));
   //////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #25 clk_i = ~clk_i;
   end
   // Whole run is about 120 cycles
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                      input string what);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   function automatic logic [63:0] oe_of(input logic [7:0] d);
      logic [63:0] r;
      for (int k = 0; k < 8; k++)
      begin
         r[8*k +: 8] = {8{~d[k]}};
      end
      return r;
   endfunction : oe_of
   // Resets, then waits out the startup load before any command
   task automatic do_reset();
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1;
   endtask : do_reset
   task automatic issue(input logic [2:0] c, input logic [6:0] idx,
                        input logic v);
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_i <= c;
      cmd_index_i <= idx;
      cmd_value_i <= v;
      cmd_dir_i <= st_dir;
      group_gen_i <= st_gen;
      group_ext_i <= st_ext;
      group_present_i <= st_pres;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      #1;
   endtask : issue
   task automatic set_dir(input logic [7:0] d);
      st_dir = d;
      exp_dir = d;
      issue(C_DIR, 7'h00, 1'b0);
      chk(dir_o, d, "dir");
      chk(ext_oe_n_o, oe_of(d), "oe");
   endtask : set_dir
   // Single-point write with its expected effect
   task automatic wr(input logic [2:0] c, input int idx, input logic v);
      logic b;
      b = (c == C_SET) ? 1'b1 : (c == C_CLR) ? 1'b0 : v;
      issue(c, idx[6:0], v);
      if (idx <= 8)
         exp_gen[idx-1] = b;
      else if (exp_dir[(idx-17)/8])
         exp_ext[idx-17] = b;
      chk(gen_out_o, exp_gen, "gen out");
      chk(ext_out_o, exp_ext, "ext out");
   endtask : wr
   task automatic rd(input logic [2:0] c, input logic [6:0] idx,
                     input logic [7:0] e);
      issue(c, idx, 1'b0);
      chk(rd_valid_o, 1'b1, "rd valid");
      chk(cmd_error_o, 1'b0, "rd error");
      if (c == C_PRD)
         chk(rd_data_o[0], e[0], "point rd");
      else
         chk(rd_data_o, e, "block rd");
   endtask : rd
   //////////////////////////////////////////////////////////////////////////
   task automatic s_points();
      set_dir(8'h81);
      wr(C_SET, 17, 1'b0);
      wr(C_SET, 80, 1'b0);
      wr(C_SET, 1, 1'b0);
      wr(C_SET, 8, 1'b0);
      wr(C_SET, 33, 1'b0);
      wr(C_CLR, 17, 1'b0);
      wr(C_COND, 80, 1'b0);
      wr(C_COND, 18, 1'b1);
      wr(C_CLR, 8, 1'b0);
   endtask : s_points
   task automatic s_errors();
      logic [2:0] ec [7] = '{C_SET, C_SET, C_CLR, C_COND, C_BRD, C_BRD, C_PRD};
      logic [6:0] ei [7] = '{7'h00, 7'h09, 7'h10, 7'h51, 7'h01, 7'h0A, 7'h10};
      for (int i = 0; i < 7; i++)
      begin
         issue(ec[i], ei[i], 1'b1);
         chk(cmd_error_o, 1'b1, "bad index");
         chk(ext_out_o, exp_ext, "no change");
      end
   endtask : s_errors
   task automatic s_group();
      set_dir(8'h40);
      wr(C_SET, 72, 1'b0);
      st_gen = 8'h07;
      st_ext = 64'hFF07_1234_5678_9ABC;
      st_pres = 5'h11;
      issue(C_GRP, 7'h00, 1'b0);
      exp_gen = 8'h07;
      exp_ext[55:48] = 8'h07;
      chk(gen_out_o, exp_gen, "grp gen");
      chk(ext_out_o, exp_ext, "grp ext");
      st_gen = 8'hA5;
      st_ext = 64'h0000_FFFF_FFFF_FFFF;
      st_pres = 5'h1F;
      issue(C_GRP, 7'h00, 1'b0);
      exp_gen = 8'hA5;
      exp_ext[55:48] = 8'h00;
      chk(gen_out_o, exp_gen, "grp gen");
      chk(ext_out_o, exp_ext, "grp ext");
      wr(C_SET, 66, 1'b0);
   endtask : s_group
   task automatic s_reads();
      @(posedge clk_i);
      gen_in_i <= 8'h5A;
      closed <= 64'h9;
      repeat (4) @(posedge clk_i);
      rd(C_BRD, 7'h00, 8'h5A);
      rd(C_BRD, 7'h02, 8'hF6);
      rd(C_BRD, 7'h08, exp_ext[55:48]);
      rd(C_BRD, 7'h09, 8'hFF);
      rd(C_PRD, 7'h11, 8'h00);
      rd(C_PRD, 7'h12, 8'h01);
      rd(C_PRD, 7'h07, 8'h01);
      rd(C_PRD, 7'h42, {7'h00, exp_ext[49]});
      // Small rack grounds blocks 5 and 9; they stay inputs here
      @(posedge clk_i);
      closed <= 64'hFF00_0000_FF00_0000;
      repeat (4) @(posedge clk_i);
      rd(C_BRD, 7'h05, 8'h00);
      rd(C_BRD, 7'h09, 8'h00);
   endtask : s_reads
   task automatic s_save();
      issue(C_SAVE, 7'h00, 1'b0);
      chk(save_o, 1'b1, "save");
      chk(save_dir_o, exp_dir, "save dir");
      chk(save_gen_o, exp_gen, "save gen");
      chk(save_ext_o, exp_ext, "save ext");
      set_dir(8'h00);
      chk(ext_out_o, exp_ext, "latch kept");
   endtask : s_save
   //////////////////////////////////////////////////////////////////////////
   initial
   begin
      {st_dir, st_gen, st_ext, st_pres} = '0;
      {exp_dir, exp_gen, exp_ext} = '0;
      // Edge at time zero, so the reset copy never starts unknown
      resetn_i <= 1'b0;
      do_reset();
      chk(dir_o, 8'h00, "start dir");
      chk(ext_oe_n_o, oe_of(8'h00), "start oe");
      set_dir(8'h01);
      set_dir(8'h0C);
      s_points();
      s_errors();
      s_group();
      s_reads();
      s_save();
      @(posedge clk_i);
      saved_valid_i <= 1'b1;
      saved_dir_i <= 8'h03;
      saved_gen_i <= 8'h3C;
      saved_ext_i <= 64'hA55A;
      do_reset();
      chk(dir_o, 8'h03, "load dir");
      chk(gen_out_o, 8'h3C, "load gen");
      chk(ext_out_o, 64'hA55A, "load ext");
      chk(ext_oe_n_o, oe_of(8'h03), "load oe");
      summarize();
   end
endmodule : xio_port_tb
